// [rtl/dpot_cfg.svh]
`ifndef DPOT_CFG_SVH
`define DPOT_CFG_SVH

// Wiper register
`define DPOT_WIPER_OFS 8'h00
`define DPOT_WIPER_W 7
`define DPOT_WIPER_RST 7'h40

// Bus addressing
`define DPOT_SLAVE_ID 7'h2e
`define DPOT_RW_READ 1'b1
`define DPOT_BITS_PER_BYTE 4'h8

// Timing
`define DPOT_CLK_MHZ 40
`define DPOT_PWRUP_US 3000
`define DPOT_PWRUP_CYC (`DPOT_PWRUP_US * `DPOT_CLK_MHZ)

`endif

// [rtl/dpot_pkg.sv]
package dpot_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
  } dpot_line_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_DEVACK,
    ST_REGADDR,
    ST_REGACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } dpot_state_t;

endpackage

// [rtl/dpot_i2c_slave.sv]
`timescale 1ns/1ps
`include "dpot_cfg.svh"

module dpot_i2c_slave #(
  parameter int PWRUP_CYC = `DPOT_PWRUP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial bus lines, open drain
  input wire dpot_pkg::dpot_line_t bus_in,
  output logic sda_out,
  output logic sda_oe,
  // Tap select toward the resistor array
  output logic [`DPOT_WIPER_W-1:0] wiper_position,
  // Power-up sequence still running
  output logic pwrup_busy
);
  import dpot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers and condition detection

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], bus_in.scl};
      sda_sync_r <= {sda_sync_r[0], bus_in.sda};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  // Data falling while clock high
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  // Data rising while clock high
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequence

  logic [31:0] pwr_cnt_r;
  logic pwr_done;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwr_cnt_r <= 32'h0;
    else if (!pwr_done)
      pwr_cnt_r <= pwr_cnt_r + 32'h1;
  end

  assign pwr_done = (pwr_cnt_r >= 32'(PWRUP_CYC));
  assign pwrup_busy = !pwr_done;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer

  function automatic logic id_match(input logic [7:0] b);
    id_match = (b[7:1] == `DPOT_SLAVE_ID);
  endfunction

  dpot_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic oe_r;
  logic mack_r;
  logic [`DPOT_WIPER_W-1:0] wiper_r;
  logic byte_end;

  assign byte_end = scl_fall && (cnt_r == `DPOT_BITS_PER_BYTE);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      oe_r <= 1'b0;
      mack_r <= 1'b0;
    end
    else if (!pwr_done)
    begin
      st_r <= ST_IDLE;
      oe_r <= 1'b0;
    end
    else if (start_det)
    begin
      // Abort whatever was under way
      st_r <= ST_DEVADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      st_r <= ST_IDLE;
      oe_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          oe_r <= 1'b0;
        end
        ST_DEVADDR, ST_REGADDR, ST_WDATA:
        begin
          if (scl_rise && cnt_r < `DPOT_BITS_PER_BYTE)
          begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
          else if (byte_end)
          begin
            if (st_r == ST_DEVADDR && id_match(sh_r))
            begin
              st_r <= ST_DEVACK;
              oe_r <= 1'b1;
            end
            else if (st_r == ST_REGADDR && sh_r == `DPOT_WIPER_OFS)
            begin
              st_r <= ST_REGACK;
              oe_r <= 1'b1;
            end
            else if (st_r == ST_WDATA)
            begin
              st_r <= ST_WACK;
              oe_r <= 1'b1;
            end
            else
            begin
              st_r <= ST_IDLE;
              oe_r <= 1'b0;
            end
          end
        end
        ST_DEVACK:
        begin
          if (scl_fall)
          begin
            cnt_r <= 4'h0;
            if (sh_r[0] == `DPOT_RW_READ)
            begin
              // Load data and present its top bit
              st_r <= ST_RDATA;
              sh_r <= {1'b0, wiper_r};
              oe_r <= 1'b1;
            end
            else
            begin
              st_r <= ST_REGADDR;
              oe_r <= 1'b0;
            end
          end
        end
        ST_REGACK:
        begin
          if (scl_fall)
          begin
            st_r <= ST_WDATA;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
          end
        end
        ST_WACK:
        begin
          if (scl_fall)
          begin
            // Back to standby after one byte
            st_r <= ST_IDLE;
            oe_r <= 1'b0;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
            cnt_r <= cnt_r + 4'h1;
          else if (byte_end)
          begin
            st_r <= ST_RACK;
            oe_r <= 1'b0;
          end
          else if (scl_fall)
          begin
            sh_r <= {sh_r[6:0], 1'b0};
            oe_r <= ~sh_r[6];
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            mack_r <= ~sda_s;
          else if (scl_fall)
          begin
            cnt_r <= 4'h0;
            if (mack_r)
            begin
              st_r <= ST_RDATA;
              sh_r <= {1'b0, wiper_r};
              oe_r <= 1'b1;
            end
            else
            begin
              st_r <= ST_IDLE;
              oe_r <= 1'b0;
            end
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
          oe_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wiper register

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wiper_r <= `DPOT_WIPER_RST;
    else if (!pwr_done)
      wiper_r <= `DPOT_WIPER_RST;
    else if (st_r == ST_WDATA && byte_end && !start_det && !stop_det)
      wiper_r <= sh_r[`DPOT_WIPER_W-1:0];
  end

  // Pull low for an acknowledge or a zero read bit
  logic oe_drv;
  assign oe_drv = oe_r;
  assign sda_oe = oe_drv;
  assign sda_out = 1'b0;
  assign wiper_position = wiper_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_addr_done;
    st_r == ST_DEVADDR && byte_end && !start_det && !stop_det;
  endsequence

  sequence s_read_nak;
    st_r == ST_RACK && scl_fall && !mack_r && !start_det && !stop_det;
  endsequence

  a_wiper_powerup: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !pwr_done |=> wiper_r == 7'h40)
    else $error("Wiper not at midscale during power-up");

  a_wiper_write_only: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pwr_done && !(st_r == ST_WDATA && byte_end) |=> $stable(wiper_r))
    else $error("Wiper changed outside write data end");

  a_idle_released: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_IDLE |-> !sda_oe)
    else $error("Data driven while idle");

  a_pwrup_ignore: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !pwr_done |=> st_r == ST_IDLE && !sda_oe)
    else $error("Bus activity during power-up");

  a_start_restart: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    start_det && pwr_done |=> st_r == ST_DEVADDR && cnt_r == 4'h0 && $stable(wiper_r))
    else $error("Start did not restart decoding");

  a_addr_match: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_addr_done ##0 (sh_r[7:1] == 7'h2e) |=> st_r == ST_DEVACK && sda_oe)
    else $error("Own address not acknowledged");

  a_addr_nack: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_addr_done ##0 (sh_r[7:1] != 7'h2e) |=> st_r == ST_IDLE ##1 !sda_oe)
    else $error("Foreign address acknowledged");

  a_read_msb: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_RDATA |-> sda_oe == !sh_r[7])
    else $error("Read bit out of order");

  a_ack_release: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_RACK |-> !sda_oe)
    else $error("Master ack slot driven");

  a_nak_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_read_nak |=> st_r == ST_IDLE [*2])
    else $error("Read continued after master nack");

  a_edge_only: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pwr_done && $changed(sda_oe) |-> $past(scl_fall || start_det || stop_det))
    else $error("Data changed while clock high");

endmodule

// [verification/dpot_master_model.sv]
`timescale 1ns/1ps
module dpot_master_model (
  // Clock and wired data level
  input wire logic sys_clk,
  input wire logic sda_in,
  // Driven lines
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // One bit: data set in low phase, sampled late in high phase
  task automatic bit_cyc(input logic b, output logic s);
    repeat (2) @(posedge sys_clk);
    sda_low <= !b;
    repeat (2) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    s = sda_in;
    scl <= 1'b0;
  endtask

  task automatic start();
    repeat (2) @(posedge sys_clk);
    sda_low <= 1'b0;
    repeat (2) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_low <= 1'b1;
    repeat (4) @(posedge sys_clk);
    scl <= 1'b0;
  endtask

  task automatic stop();
    repeat (2) @(posedge sys_clk);
    sda_low <= 1'b1;
    repeat (2) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    sda_low <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////
  // Sends n bits; a full byte also fetches the acknowledge
  task automatic put_byte(input logic [7:0] d, input int n, output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--)
      bit_cyc(d[i], s);
    if (n == 8)
    begin
      bit_cyc(1'b1, s);
      ack = !s;
    end
  endtask

  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b1, s);
      d[i] = s;
    end
    bit_cyc(!mack, s);
  endtask
endmodule

// [verification/test_dpot_i2c_slave.sv]
`timescale 1ns/1ps
`include "dpot_cfg.svh"
module test_dpot_i2c_slave;
  import dpot_pkg::*;
  localparam logic [7:0] ID_W = {`DPOT_SLAVE_ID, 1'b0};
  localparam logic [7:0] ID_R = {`DPOT_SLAVE_ID, 1'b1};
  logic sys_clk;
  logic rst_n;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic pwrup_busy;
  logic [`DPOT_WIPER_W-1:0] wiper_position;
  logic sda_w;
  dpot_line_t bus_w;
  logic [7:0] wv [3] = '{8'h7f, 8'h00, 8'h95};
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  // Open-drain wire with pull-up
  assign sda_w = !(sda_low | (sda_oe & !sda_out));
  assign bus_w = {scl, sda_w};

  dpot_i2c_slave #(.PWRUP_CYC(20)) dpot_i2c_slave_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_in(bus_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wiper_position(wiper_position),
    .pwrup_busy(pwrup_busy)
  );

  dpot_master_model dpot_master_model_i (
    .sys_clk(sys_clk),
    .sda_in(sda_w),
    .scl(scl),
    .sda_low(sda_low)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] id, input logic [7:0] rg, input logic [7:0] dt,
                    output logic [2:0] a);
    dpot_master_model_i.start();
    dpot_master_model_i.put_byte(id, 8, a[2]);
    dpot_master_model_i.put_byte(rg, 8, a[1]);
    dpot_master_model_i.put_byte(dt, 8, a[0]);
    dpot_master_model_i.stop();
  endtask

  task automatic rd(input logic [7:0] exp);
    logic [2:0] a;
    logic [7:0] d0;
    logic [7:0] d1;
    dpot_master_model_i.start();
    dpot_master_model_i.put_byte(ID_W, 8, a[2]);
    dpot_master_model_i.put_byte(8'h00, 8, a[1]);
    dpot_master_model_i.start();
    dpot_master_model_i.put_byte(ID_R, 8, a[0]);
    dpot_master_model_i.get_byte(1'b1, d0);
    dpot_master_model_i.get_byte(1'b0, d1);
    check("rd_ack", {5'h00, a}, 8'h07);
    check("rd_data0", d0, exp);
    check("rd_data1", d1, exp);
    repeat (4) @(posedge sys_clk);
    check("rd_release", {7'h00, sda_oe}, 8'h00);
    dpot_master_model_i.stop();
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [2:0] a;
    logic ign;
    logic [7:0] d;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    check("wiper_rst", {1'b0, wiper_position}, 8'h40);
    check("sda_oe_rst", {7'h00, sda_oe}, 8'h00);
    check("sda_out", {7'h00, sda_out}, 8'h00);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check("busy", {7'h00, pwrup_busy}, 8'h01);
    // Start lands while power-up still runs
    wr(ID_W, 8'h00, 8'h11, a);
    check("pwrup_ack", {5'h00, a}, 8'h00);
    check("pwrup_wiper", {1'b0, wiper_position}, 8'h40);
    check("busy_done", {7'h00, pwrup_busy}, 8'h00);
    foreach (wv[i])
    begin
      wr(ID_W, 8'h00, wv[i], a);
      check("wr_ack", {5'h00, a}, 8'h07);
      check("wiper", {1'b0, wiper_position}, {1'b0, wv[i][6:0]});
      check("wr_release", {7'h00, sda_oe}, 8'h00);
    end
    wr({`DPOT_SLAVE_ID ^ 7'h01, 1'b0}, 8'h00, 8'h22, a);
    check("bad_id_ack", {5'h00, a}, 8'h00);
    wr(ID_W, 8'h01, 8'h22, a);
    check("bad_reg_ack", {5'h00, a}, 8'h04);
    check("bad_wiper", {1'b0, wiper_position}, 8'h15);
    rd(8'h15);
    // Data byte cut short by a new start
    dpot_master_model_i.start();
    dpot_master_model_i.put_byte(ID_W, 8, ign);
    dpot_master_model_i.put_byte(8'h00, 8, ign);
    dpot_master_model_i.put_byte(8'h3c, 4, ign);
    rd(8'h15);
    // Read straight after the address byte
    dpot_master_model_i.start();
    dpot_master_model_i.put_byte(ID_R, 8, ign);
    dpot_master_model_i.get_byte(1'b0, d);
    dpot_master_model_i.stop();
    check("rd_direct_ack", {7'h00, ign}, 8'h01);
    check("rd_direct", d, 8'h15);
    give_verdict();
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_fail++;
      give_verdict();
    end
  end
endmodule
